// [dma_crc_pkg.sv]
// Package for the DMA global control and CRC engine block.
// Assumes a single 20 MHz clock and a plain strobe-based register port.
package dma_crc_pkg;
    // Register word indices; byte address is index times four
    localparam logic [3:0] ADDR_GLOBAL_CONTROL = 4'h0;
    localparam logic [3:0] ADDR_GLOBAL_STATUS = 4'h1;
    localparam logic [3:0] ADDR_LAST_ADDRESS = 4'h2;
    localparam logic [3:0] ADDR_ENGINE_CONTROL = 4'h3;
    localparam logic [3:0] ADDR_VALUE_SEED = 4'h4;
    localparam logic [3:0] ADDR_TAP_MASK = 4'h5;
    // Global control fields
    localparam int GLOBAL_ENABLE_BIT = 15;
    localparam int SUSPEND_BIT = 12;
    localparam int ACTIVE_FLAG_BIT = 11;
    // Status fields
    localparam int DIRECTION_BIT = 3;
    localparam int CHANNEL_LSB = 0;
    // Engine control fields
    localparam int BYTE_ORDER_LSB = 28;
    localparam int REORDER_WRITE_BIT = 27;
    localparam int REFLECT_BIT = 24;
    localparam int POLYNOMIAL_LENGTH_MINUS_ONE_LSB = 8;
    localparam int ENGINE_ENABLE_BIT = 7;
    localparam int APPEND_BIT = 6;
    localparam int TYPE_BIT = 5;
    localparam int SELECT_LSB = 0;
    localparam logic [31:0] ENGINE_CONTROL_MASK = 32'h3900_1fe7;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
    localparam logic [31:0] CHECKSUM_MASK = 32'h0000_ffff;
    typedef enum logic [1:0] {
        ORDER_NONE = 2'b00,
        ORDER_WORD_REVERSE = 2'b01,
        ORDER_HALF_SWAP = 2'b10,
        ORDER_HALF_REVERSE = 2'b11
    } byte_order_t;
endpackage

// [dma_global_control_crc.sv]
// Global DMA control/status plus the shared CRC and checksum engine.
// Assumes channel datapath presents one 32-bit unit per beat, synchronously.
// What this block does
// - Global enable bit switches module on
// - Suspend bit holds off all transfers but the append result write
// - Active flag is set while global enable is on or a channel is busy
// - Status records last access direction
// - Status holds most recent channel number
// - Capture address of every DMA access made while enabled and not suspended
// - Byte order field reorders engine input
// - Write order bit reorders destination data of engine-routed beats
// - Bit order bit selects reflected processing
// - LFSR length is field plus one
// - Engine enable routes selected channel traffic
// - Append mode consumes data, writes result
// - Normal mode forwards data to destination
// - Type bit picks checksum or LFSR
// - Select field attaches engine to channel
// - Reordered writes forbid append mode
// - Writing value register seeds engine
// - Reading value in LFSR mode masks bits above length
// - Unimplemented bits read zero
// - Checksum mode uses low sixteen bits
// - Tap mask bits enable feedback XOR
module dma_global_control_crc
    import dma_crc_pkg::*;
#(
    parameter int DATA_WIDTH = 32,
    parameter int CHANNEL_BITS = 3
) (
    input wire logic clock, // System clock
    input wire logic reset, // Synchronous, active high
    input wire logic [3:0] reg_address, // Register word index
    input wire logic [31:0] reg_write_data, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    output logic [31:0] reg_read_data, // Read data, cycle after strobe
    input wire logic beat_valid, // Channel moves one unit now
    input wire logic [CHANNEL_BITS-1:0] beat_channel, // Channel number
    input wire logic beat_is_read, // Access is a bus read
    input wire logic [31:0] beat_address, // Bus address of access
    input wire logic [DATA_WIDTH-1:0] beat_data, // Source data
    input wire logic beat_busy, // Some channel is transferring
    input wire logic block_done, // Selected channel block complete
    output logic transfers_allowed, // Channels may run
    output logic engine_attached, // Selected channel routed through engine
    output logic [CHANNEL_BITS-1:0] attached_channel, // Engine channel
    output logic dest_write_enable, // Write beat to destination
    output logic [DATA_WIDTH-1:0] dest_data, // Data to destination
    output logic result_write, // Pulse: write result to dest start
    output logic [31:0] result_data // Result for the append write
);
    logic enable_reg;
    logic suspend_reg;
    logic active_reg;
    logic direction_reg;
    logic [CHANNEL_BITS-1:0] last_channel_reg;
    logic [31:0] last_address_reg;
    logic [31:0] engine_control_reg;
    logic [31:0] crc_reg;
    logic [31:0] crc_next;
    logic [31:0] tap_mask_reg;
    logic [31:0] engine_control_next;
    logic [31:0] read_next;
    logic [DATA_WIDTH-1:0] ordered_data;
    logic engine_beat;
    byte_order_t byte_order;
    logic reorder_write;
    logic reflect;
    logic [4:0] polynomial_length_minus_one;
    logic engine_enable;
    logic append_mode;
    logic checksum_type;
    logic [CHANNEL_BITS-1:0] engine_select;

    assign byte_order = byte_order_t'(engine_control_reg[BYTE_ORDER_LSB +: 2]);
    assign reorder_write = engine_control_reg[REORDER_WRITE_BIT];
    assign reflect = engine_control_reg[REFLECT_BIT];
    assign polynomial_length_minus_one = engine_control_reg[POLYNOMIAL_LENGTH_MINUS_ONE_LSB +: 5];
    assign engine_enable = engine_control_reg[ENGINE_ENABLE_BIT];
    assign append_mode = engine_control_reg[APPEND_BIT];
    assign checksum_type = engine_control_reg[TYPE_BIT];
    assign engine_select = engine_control_reg[SELECT_LSB +: CHANNEL_BITS];

    function automatic logic [31:0] reorder(input logic [31:0] d,
                                            input byte_order_t mode);
        unique case (mode)
            ORDER_NONE: reorder = d;
            ORDER_WORD_REVERSE: reorder = {d[7:0], d[15:8], d[23:16], d[31:24]};
            ORDER_HALF_SWAP: reorder = {d[15:0], d[31:16]};
            ORDER_HALF_REVERSE: reorder = {d[23:16], d[31:24], d[7:0], d[15:8]};
        endcase
    endfunction

    function automatic logic [31:0] bit_reverse(input logic [31:0] d);
        for (int i = 0; i < 32; i++) begin
            bit_reverse[i] = d[31-i];
        end
    endfunction

    // Mask of the active polynomial width, polynomial_length_minus_one+1 bits
    function automatic logic [31:0] length_mask(input logic [4:0] len);
        for (int i = 0; i < 32; i++) begin
            length_mask[i] = (i <= int'(len));
        end
    endfunction

    // One's complement 16-bit add with end-around carry
    function automatic logic [15:0] ones_add(input logic [15:0] a,
                                             input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        ones_add = s[15:0] + {15'h0000, s[16]};
    endfunction

    assign ordered_data = reorder(beat_data, byte_order);

    // Only the attached channel feeds the engine
    assign engine_beat = beat_valid && enable_reg && !suspend_reg
        && engine_enable && (beat_channel == engine_select);

    // Engine next state: LFSR or running checksum
    always_comb begin
        logic [31:0] din;
        logic [31:0] state;
        logic [31:0] mask;
        logic fb;
        din = ZERO_WORD;
        state = crc_reg;
        mask = length_mask(polynomial_length_minus_one);
        fb = 1'b0;
        crc_next = crc_reg;
        if (checksum_type) begin
            din = reflect ? bit_reverse(ordered_data) : ordered_data;
            state = {16'h0000, ones_add(ones_add(crc_reg[15:0], din[31:16]),
                                        din[15:0])};
            crc_next = state;
        end else begin
            din = reflect ? ordered_data : bit_reverse(ordered_data);
            // din[0] is always the first bit to enter
            for (int i = 0; i < 32; i++) begin
                fb = state[polynomial_length_minus_one] ^ din[i];
                state = ((state << 1) ^ ({32{fb}} & tap_mask_reg)) & mask;
            end
            crc_next = state;
        end
    end

    // Global control register
    always_ff @(posedge clock) begin
        if (reset) begin
            enable_reg <= 1'b0;
            suspend_reg <= 1'b0;
        end else if (reg_write && reg_address == ADDR_GLOBAL_CONTROL) begin
            enable_reg <= reg_write_data[GLOBAL_ENABLE_BIT];
            suspend_reg <= reg_write_data[SUSPEND_BIT];
        end
    end

    // Engine control; append cannot be set while reordered writes are on
    always_comb begin
        engine_control_next = reg_write_data & ENGINE_CONTROL_MASK;
        if (engine_control_next[REORDER_WRITE_BIT]) begin
            engine_control_next[APPEND_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            engine_control_reg <= ZERO_WORD;
            tap_mask_reg <= ZERO_WORD;
        end else if (reg_write) begin
            if (reg_address == ADDR_ENGINE_CONTROL) begin
                engine_control_reg <= engine_control_next;
            end
            if (reg_address == ADDR_TAP_MASK) begin
                tap_mask_reg <= reg_write_data;
            end
        end
    end

    // Seed write beats a data beat in the same cycle
    always_ff @(posedge clock) begin
        if (reset) begin
            crc_reg <= ZERO_WORD;
        end else if (reg_write && reg_address == ADDR_VALUE_SEED) begin
            crc_reg <= checksum_type ? (reg_write_data & CHECKSUM_MASK)
                                     : reg_write_data;
        end else if (engine_beat) begin
            crc_reg <= crc_next;
        end
    end

    // Access tracking
    always_ff @(posedge clock) begin
        if (reset) begin
            direction_reg <= 1'b0;
            last_channel_reg <= '0;
            last_address_reg <= ZERO_WORD;
        end else if (beat_valid && enable_reg && !suspend_reg) begin
            direction_reg <= beat_is_read;
            last_channel_reg <= beat_channel;
            last_address_reg <= beat_address;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            active_reg <= 1'b0;
        end else begin
            active_reg <= enable_reg || beat_busy;
        end
    end

    // Datapath controls toward the channels
    always_ff @(posedge clock) begin
        if (reset) begin
            transfers_allowed <= 1'b0;
            engine_attached <= 1'b0;
            attached_channel <= '0;
            dest_write_enable <= 1'b0;
            dest_data <= '0;
            result_write <= 1'b0;
            result_data <= ZERO_WORD;
        end else begin
            transfers_allowed <= enable_reg && !suspend_reg;
            engine_attached <= enable_reg && engine_enable;
            attached_channel <= engine_select;
            dest_write_enable <= beat_valid && enable_reg && !suspend_reg
                && !(engine_beat && append_mode);
            dest_data <= (engine_beat && reorder_write) ? ordered_data
                                                        : beat_data;
            result_write <= block_done && enable_reg && engine_enable
                && append_mode;
            result_data <= checksum_type ? {16'h0000, ~crc_reg[15:0]}
                                         : crc_reg & length_mask(polynomial_length_minus_one);
        end
    end

    // Register read mux; unmapped reads return zero
    always_comb begin
        read_next = ZERO_WORD;
        unique case (reg_address)
            ADDR_GLOBAL_CONTROL: begin
                read_next[GLOBAL_ENABLE_BIT] = enable_reg;
                read_next[SUSPEND_BIT] = suspend_reg;
                read_next[ACTIVE_FLAG_BIT] = active_reg;
            end
            ADDR_GLOBAL_STATUS: begin
                read_next[DIRECTION_BIT] = direction_reg;
                read_next[CHANNEL_LSB +: CHANNEL_BITS] = last_channel_reg;
            end
            ADDR_LAST_ADDRESS: read_next = last_address_reg;
            ADDR_ENGINE_CONTROL: read_next = engine_control_reg;
            ADDR_VALUE_SEED: begin
                if (checksum_type) begin
                    read_next = {16'h0000, ~crc_reg[15:0]};
                end else begin
                    read_next = crc_reg & length_mask(polynomial_length_minus_one);
                end
            end
            ADDR_TAP_MASK: read_next = tap_mask_reg;
            default: read_next = ZERO_WORD;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            reg_read_data <= ZERO_WORD;
        end else if (reg_read) begin
            reg_read_data <= read_next;
        end else begin
            reg_read_data <= ZERO_WORD;
        end
    end
endmodule // dma_global_control_crc

// [dma_crc_properties.sv]
// Checker for the DMA global control and CRC block.
// Sees the top module's ports only; bound to it at the foot of the file.
module dma_crc_checker
    import dma_crc_pkg::*;
#(
    parameter int DATA_WIDTH = 32,
    parameter int CHANNEL_BITS = 3
) (
    input wire logic clock, // Clock
    input wire logic reset, // Sync reset
    input wire logic [3:0] reg_address, // Word index
    input wire logic [31:0] reg_write_data, // Write data
    input wire logic reg_write, // Write strobe
    input wire logic reg_read, // Read strobe
    input wire logic [31:0] reg_read_data, // Read data
    input wire logic beat_valid, // Beat
    input wire logic [CHANNEL_BITS-1:0] beat_channel, // Channel
    input wire logic beat_is_read, // Direction
    input wire logic [31:0] beat_address, // Address
    input wire logic [DATA_WIDTH-1:0] beat_data, // Source data
    input wire logic block_done, // Block end
    input wire logic transfers_allowed, // Run gate
    input wire logic engine_attached, // Engine routed
    input wire logic [CHANNEL_BITS-1:0] attached_channel, // Engine channel
    input wire logic dest_write_enable, // Dest write
    input wire logic [DATA_WIDTH-1:0] dest_data, // Dest data
    input wire logic result_write // Result pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    logic [31:0] addr_seen_reg;
    logic [CHANNEL_BITS:0] stat_seen_reg;
    // Mirrors only accepted beats, as the status registers should
    always_ff @(posedge clock) begin
        if (reset) begin
            addr_seen_reg <= 32'h0;
            stat_seen_reg <= '0;
        end else if (beat_valid && transfers_allowed) begin
            addr_seen_reg <= beat_address;
            stat_seen_reg <= {beat_is_read, beat_channel};
        end
    end
    AST_READ_IDLE: assert property (!reg_read |=> reg_read_data == 32'h0)
        else $error("read data not zero outside a read");
    AST_UNMAPPED: assert property (reg_read && reg_address > ADDR_TAP_MASK
        |=> reg_read_data == 32'h0) else $error("unmapped read not zero");
    AST_CTRL_BITS: assert property (reg_read && reg_address == 4'h0
        |=> (reg_read_data & ~32'h0000_9800) == 32'h0)
        else $error("control reads unused bits");
    AST_ENG_BITS: assert property (reg_read && reg_address == 4'h3
        |=> (reg_read_data & ~ENGINE_CONTROL_MASK) == ZERO_WORD)
        else $error("engine control reads unused bits");
    AST_NO_APPEND: assert property (reg_read && reg_address == 4'h3
        |=> !(reg_read_data[27] && reg_read_data[6]))
        else $error("append set beside write order");
    AST_STATUS: assert property (reg_read && reg_address == 4'h1
        |=> reg_read_data == 32'($past(stat_seen_reg)))
        else $error("status differs from last beat");
    AST_LAST_ADDR: assert property (reg_read && reg_address == 4'h2
        |=> reg_read_data == $past(addr_seen_reg))
        else $error("last address differs");
    AST_ALLOW: assert property (reg_write && reg_address == 4'h0
        |-> ##2 transfers_allowed == ($past(reg_write_data[15], 2)
        && !$past(reg_write_data[12], 2))) else $error("run gate wrong");
    AST_SELECT: assert property (reg_write && reg_address == 4'h3
        |-> ##2 attached_channel == $past(reg_write_data[2:0], 2))
        else $error("engine channel wrong");
    AST_PASS: assert property (beat_valid && transfers_allowed
        && !engine_attached |=> dest_write_enable
        && dest_data == $past(beat_data)) else $error("plain beat lost");
    AST_HOLD: assert property (!(beat_valid && transfers_allowed)
        |=> !dest_write_enable) else $error("dest write without beat");
    AST_RESULT: assert property (!block_done |=> !result_write)
        else $error("result write without block end");
endmodule // dma_crc_checker

bind dma_global_control_crc dma_crc_checker #(.DATA_WIDTH(DATA_WIDTH),
    .CHANNEL_BITS(CHANNEL_BITS)) chk_u (.clock(clock), .reset(reset),
    .reg_address(reg_address), .reg_write_data(reg_write_data),
    .reg_write(reg_write), .reg_read(reg_read),
    .reg_read_data(reg_read_data), .beat_valid(beat_valid),
    .beat_channel(beat_channel), .beat_is_read(beat_is_read),
    .beat_address(beat_address), .beat_data(beat_data),
    .block_done(block_done), .transfers_allowed(transfers_allowed),
    .engine_attached(engine_attached), .attached_channel(attached_channel),
    .dest_write_enable(dest_write_enable), .dest_data(dest_data),
    .result_write(result_write));

// [channel_model.sv]
// Channel datapath stand-in: issues single beats and block-end pulses.
// Assumes the bench calls its tasks in the block's clock domain.
module channel_model (
    input wire logic clock, // System clock
    output logic beat_valid, // One unit moved
    output logic [2:0] beat_channel, // Channel number
    output logic beat_is_read, // Bus read access
    output logic [31:0] beat_address, // Access address
    output logic [31:0] beat_data, // Source data
    output logic beat_busy, // Channel running
    output logic block_done // Block finished
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        {beat_valid, beat_is_read, beat_busy, block_done} = 4'h0;
        {beat_channel, beat_address, beat_data} = 67'h0;
    end
    task automatic send(input logic [2:0] ch, input logic rd,
                        input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        beat_valid <= 1'b1;
        beat_busy <= 1'b1;
        {beat_channel, beat_is_read, beat_address, beat_data} <= {ch, rd, a, d};
        @(posedge clock);
        beat_valid <= 1'b0;
        beat_busy <= 1'b0;
        // Released address and data lines show the inverse so stale values never match
        beat_address <= ~a;
        beat_data <= ~d;
    endtask
    task automatic finish_block();
        @(posedge clock);
        block_done <= 1'b1;
        @(posedge clock);
        block_done <= 1'b0;
    endtask
endmodule // channel_model

// [tb_top.sv]
// Self-checking bench for the DMA global control and CRC block.
// Assumes a 20 MHz clock; registers reached over the strobe port.
module tb_top
    import dma_crc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [3:0] reg_address = 4'h0;
    logic [31:0] reg_write_data = 32'h0;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [31:0] reg_read_data, beat_address, beat_data, dest_data, result_data;
    logic beat_valid, beat_is_read, beat_busy, block_done;
    logic transfers_allowed, engine_attached, dest_write_enable, result_write;
    logic [2:0] beat_channel, attached_channel;
    logic [4:0] polynomial_length_minus_one [4] = '{5'h00, 5'h07, 5'h0f, 5'h1f};
    int n_fail = 0;
    int checked = 0;
    always #25 clock = ~clock;
    channel_model ch_u (.clock(clock), .beat_valid(beat_valid),
        .beat_channel(beat_channel), .beat_is_read(beat_is_read),
        .beat_address(beat_address), .beat_data(beat_data),
        .beat_busy(beat_busy), .block_done(block_done));
    dma_global_control_crc dut_u (.clock(clock), .reset(reset),
        .reg_address(reg_address), .reg_write_data(reg_write_data),
        .reg_write(reg_write), .reg_read(reg_read),
        .reg_read_data(reg_read_data), .beat_valid(beat_valid),
        .beat_channel(beat_channel), .beat_is_read(beat_is_read),
        .beat_address(beat_address), .beat_data(beat_data),
        .beat_busy(beat_busy), .block_done(block_done),
        .transfers_allowed(transfers_allowed),
        .engine_attached(engine_attached),
        .attached_channel(attached_channel),
        .dest_write_enable(dest_write_enable), .dest_data(dest_data),
        .result_write(result_write), .result_data(result_data));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_address, reg_write_data, reg_write} <= {a, d, 1'b1};
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        @(posedge clock);
        {reg_address, reg_read} <= {a, 1'b1};
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk(reg_read_data, exp);
    endtask
    function automatic logic [31:0] swap(input logic [1:0] m, input logic [31:0] d);
        case (m)
            2'b01: swap = {d[7:0], d[15:8], d[23:16], d[31:24]};
            2'b10: swap = {d[15:0], d[31:16]};
            2'b11: swap = {d[23:16], d[31:24], d[7:0], d[15:8]};
            default: swap = d;
        endcase
    endfunction
    task automatic conclude();
        if (n_fail == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(4'(i), 32'h0);
        end
        wr(ADDR_GLOBAL_CONTROL, 32'hffff_ffff);
        rd(ADDR_GLOBAL_CONTROL, 32'h0000_9800);
        ch_u.send(3'h5, 1'b1, 32'hdead_0010, 32'h1122_3344);
        @(negedge clock);
        chk(32'(dest_write_enable), 32'h0);
        rd(ADDR_GLOBAL_STATUS, 32'h0);
        wr(ADDR_GLOBAL_CONTROL, 32'h0000_8000);
        ch_u.send(3'h5, 1'b1, 32'hdead_0010, 32'h1122_3344);
        @(negedge clock);
        chk(dest_data, 32'h1122_3344);
        rd(ADDR_GLOBAL_STATUS, 32'h0000_000d);
        rd(ADDR_LAST_ADDRESS, 32'hdead_0010);
        ch_u.send(3'h2, 1'b0, 32'h0000_0abc, 32'h0);
        rd(ADDR_GLOBAL_STATUS, 32'h0000_0002);
        wr(ADDR_ENGINE_CONTROL, 32'hffff_ffff);
        rd(ADDR_ENGINE_CONTROL, 32'h3900_1fa7);
        foreach (polynomial_length_minus_one[i]) begin
            wr(ADDR_ENGINE_CONTROL, {19'h0, polynomial_length_minus_one[i], 8'h0});
            wr(ADDR_VALUE_SEED, 32'hffff_ffff);
            rd(ADDR_VALUE_SEED, 32'hffff_ffff >> (31 - polynomial_length_minus_one[i]));
        end
        for (int m = 0; m < 4; m++) begin
            wr(ADDR_ENGINE_CONTROL, (32'(m) << 28) | 32'h0800_00a2);
            ch_u.send(3'h2, 1'b1, 32'h0, 32'h1122_3344);
            @(negedge clock);
            chk(dest_data, swap(2'(m), 32'h1122_3344));
        end
        wr(ADDR_ENGINE_CONTROL, 32'h1000_00a2);
        wr(ADDR_VALUE_SEED, 32'habcd_1234);
        rd(ADDR_VALUE_SEED, 32'h0000_edcb);
        ch_u.send(3'h3, 1'b0, 32'h0, 32'h0102_0304);
        rd(ADDR_VALUE_SEED, 32'h0000_edcb);
        ch_u.send(3'h2, 1'b0, 32'h0, 32'h0102_0304);
        @(negedge clock);
        chk(dest_data, 32'h0102_0304);
        rd(ADDR_VALUE_SEED, 32'h0000_e7c7);
        wr(ADDR_ENGINE_CONTROL, 32'h1000_00e2);
        ch_u.send(3'h2, 1'b0, 32'h0, 32'h0102_0304);
        @(negedge clock);
        chk(32'(dest_write_enable), 32'h0);
        ch_u.finish_block();
        @(negedge clock);
        chk({31'h0, result_write}, 32'h1);
        chk(result_data, 32'h0000_e1c3);
        // Two-bit LFSR, one data bit: tap and bit order both show in result
        wr(ADDR_TAP_MASK, 32'h0000_0001);
        wr(ADDR_ENGINE_CONTROL, 32'h0100_0182);
        wr(ADDR_VALUE_SEED, 32'h0);
        ch_u.send(3'h2, 1'b0, 32'h0, 32'h0000_0001);
        rd(ADDR_VALUE_SEED, 32'h0000_0002);
        wr(ADDR_ENGINE_CONTROL, 32'h0000_0182);
        wr(ADDR_VALUE_SEED, 32'h0);
        ch_u.send(3'h2, 1'b0, 32'h0, 32'h0000_0001);
        rd(ADDR_VALUE_SEED, 32'h0000_0001);
        wr(ADDR_TAP_MASK, 32'h0);
        wr(ADDR_ENGINE_CONTROL, 32'h0100_0182);
        wr(ADDR_VALUE_SEED, 32'h0);
        ch_u.send(3'h2, 1'b0, 32'h0, 32'h0000_0001);
        rd(ADDR_VALUE_SEED, 32'h0);
        wr(ADDR_GLOBAL_CONTROL, 32'h0);
        @(posedge clock);
        rd(ADDR_GLOBAL_CONTROL, 32'h0);
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock);
        n_fail++;
        conclude();
    end
endmodule // tb_top
